// ===== rtl/spi_cmd_defines.svh
`ifndef SPI_CMD_DEFINES_SVH
`define SPI_CMD_DEFINES_SVH

// frame layout
`define INSTR_BITS        8
`define ANSWER_BITS       16
`define FRAME_CLOCKS      24
// refusal answer fields
`define REFUSE_MARK_BIT   15
`define REFUSE_OPC_BIT    14
`define REFUSE_EOC_BIT    13
`define REFUSE_BUSY_BIT   10
// status answer fields
`define STAT_EOC_BIT      13
`define STAT_CHAN_BIT     3
`define STAT_EN_BIT       2
// opcodes, upper nibble and fixed low bits
`define OP_STATUS         8'h88
`define OP_ADC_CTRL_HI    4'h9
`define OP_ADC_READ       8'h80
`define OP_LOW_ZERO       2'h0
`define CTRL_CHAN_BIT     3
`define CTRL_EN_BIT       2
// adc
`define ADC_BITS          11
`define CONV_TIME_US      115
`define WAKE_TIME_MS      250
`define CLK_MHZ           25
`define CONV_CYCLES       (`CONV_TIME_US * `CLK_MHZ)
`define WAKE_CYCLES       (`WAKE_TIME_MS * 1000 * `CLK_MHZ)

`endif

// ===== rtl/spi_cmd_pkg.sv
`include "spi_cmd_defines.svh"

package spi_cmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_ANSWER,
    ST_DONE
  } link_state_e;

  typedef logic [`ANSWER_BITS-1:0] answer_t;
  typedef logic [`ADC_BITS-1:0]    adc_code_t;
endpackage : spi_cmd_pkg

// ===== rtl/spi_slave_command_port.sv

`include "spi_cmd_defines.svh"

module spi_slave_command_port
  import spi_cmd_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES,
  parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
  // clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      reset_i,
  // serial link pins
  input  wire logic      sclk_i,
  input  wire logic      mosi_i,
  input  wire logic      ss_n_i,
  output logic           miso_o,
  output logic           miso_oe_n_o,
  // converter sample input
  input  wire adc_code_t adc_sample_i,
  // status outputs
  output logic           busy_o,
  output logic           adc_enable_o,
  output logic           adc_chan_o,
  output logic           conv_done_o
);
  logic sclk_s;
  logic mosi_s;
  logic ss_n_s;

  // sclk and mosi synced low-at-reset, select synced high-at-reset
  spi_sync2 u_sync_sclk (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (sclk_i),
    .rst_val_i (1'b0),
    .sync_o    (sclk_s)
  );
  spi_sync2 u_sync_mosi (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (mosi_i),
    .rst_val_i (1'b0),
    .sync_o    (mosi_s)
  );
  spi_sync2 u_sync_ss (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (~ss_n_i),
    .rst_val_i (1'b1),
    .sync_o    (ss_n_s)
  );

  // link state
  link_state_e             state_q, state_d;
  logic                    sclk_prev_q, sclk_prev_d;
  logic [`INSTR_BITS-1:0]  instr_q, instr_d;
  logic [4:0]              count_q, count_d;
  answer_t                 answer_q, answer_d;
  logic                    miso_q, miso_d;
  logic                    oe_n_q, oe_n_d;
  // adc and init state
  logic [31:0]             wake_q, wake_d;
  logic                    busy_q, busy_d;
  logic [31:0]             conv_q, conv_d;
  logic                    eoc_q, eoc_d;
  logic                    en_q, en_d;
  logic                    chan_q, chan_d;
  adc_code_t               result_q, result_d;

  logic                    rise;
  logic                    fall;
  logic [`INSTR_BITS-1:0]  instr_full;
  logic                    is_status;
  logic                    is_ctrl;
  logic                    is_read;
  logic                    unknown_opcode_flag;
  answer_t                 refusal;
  answer_t                 reply;
  logic                    refuse;
  logic                    start_conv;

  // pin edges arrive three ref clocks late
  // so sclk phases must span four ref clocks
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;
  assign instr_full = {instr_q[`INSTR_BITS-2:0], mosi_s};

  assign is_status = (instr_full == `OP_STATUS);
  assign is_ctrl   = (instr_full[7:4] == `OP_ADC_CTRL_HI) && (instr_full[1:0] == `OP_LOW_ZERO);
  assign is_read   = (instr_full == `OP_ADC_READ);
  assign unknown_opcode_flag = ~(is_status | is_ctrl | is_read);

  always_comb begin
    refusal = '0;
    refusal[`REFUSE_MARK_BIT] = 1'b1;
    refusal[`REFUSE_OPC_BIT]  = unknown_opcode_flag;
    refusal[`REFUSE_EOC_BIT]  = eoc_q;
    refusal[`REFUSE_BUSY_BIT] = busy_q;
    // busy forces refusal
    // conversion start while running is refused too
    refuse = busy_q | unknown_opcode_flag |
             (is_ctrl & instr_full[`CTRL_EN_BIT] & ~eoc_q);
    reply = '0;
    if (refuse) begin
      reply = refusal;
    end else if (is_status) begin
      reply[`STAT_EOC_BIT]  = eoc_q;
      reply[`STAT_CHAN_BIT] = chan_q;
      reply[`STAT_EN_BIT]   = en_q;
    end else if (is_ctrl) begin
      reply[`STAT_EOC_BIT]  = eoc_q;
      reply[`STAT_CHAN_BIT] = instr_full[`CTRL_CHAN_BIT];
      reply[`STAT_EN_BIT]   = instr_full[`CTRL_EN_BIT];
    end else begin
      reply[`STAT_EOC_BIT] = eoc_q;
      reply[`ADC_BITS:1]   = result_q;
    end
  end

  always_comb begin
    state_d     = state_q;
    sclk_prev_d = sclk_s;
    instr_d     = instr_q;
    count_d     = count_q;
    answer_d    = answer_q;
    miso_d      = miso_q;
    oe_n_d      = oe_n_q;
    start_conv  = 1'b0;
    en_d        = en_q;
    chan_d      = chan_q;
    // back to idle on select high
    if (ss_n_s) begin
      state_d = ST_IDLE;
      oe_n_d  = 1'b1;
      miso_d  = 1'b0;
      count_d = '0;
      // stale answer bits are reloaded at the eighth bit
    end else begin
      // only miso driven, never the clock
      oe_n_d = 1'b0;
      case (state_q)
        ST_IDLE: begin
          // drop bits left by a cut frame
          instr_d = '0;
          state_d = ST_INSTR;
          if (rise) begin
            instr_d = {instr_q[`INSTR_BITS-2:0], mosi_s};
            count_d = 5'd1;
          end
        end
        ST_INSTR: begin
          if (rise) begin
            instr_d = instr_full;
            count_d = count_q + 5'd1;
            if (count_q == 5'(`INSTR_BITS - 1)) begin
              answer_d = reply;
              state_d  = ST_ANSWER;
              if (!refuse && is_ctrl) begin
                en_d       = instr_full[`CTRL_EN_BIT];
                chan_d     = instr_full[`CTRL_CHAN_BIT];
                start_conv = instr_full[`CTRL_EN_BIT];
              end
            end
          end
        end
        ST_ANSWER: begin
          if (fall) begin
            miso_d   = answer_q[`ANSWER_BITS-1];
            answer_d = {answer_q[`ANSWER_BITS-2:0], 1'b0};
          end
          if (rise) begin
            count_d = count_q + 5'd1;
            if (count_q == 5'(`FRAME_CLOCKS - 1)) begin
              state_d = ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (fall) begin
            miso_d = 1'b0;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_comb begin
    wake_d   = wake_q;
    busy_d   = busy_q;
    conv_d   = conv_q;
    eoc_d    = eoc_q;
    result_d = result_q;
    if (busy_q) begin
      if (wake_q == WAKE_CYCLES - 1) begin
        busy_d = 1'b0;
      end else begin
        wake_d = wake_q + 32'd1;
      end
    end
    if (start_conv) begin
      eoc_d  = 1'b0;
      conv_d = '0;
    end else if (!eoc_q) begin
      if (conv_q == CONV_CYCLES - 1) begin
        eoc_d    = 1'b1;
        // sample latched as the conversion ends
        result_d = adc_sample_i;
      end else begin
        conv_d = conv_q + 32'd1;
      end
    end
  end

  // one register bank for link and converter state
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q     <= ST_IDLE;
      sclk_prev_q <= 1'b0;
      instr_q     <= '0;
      count_q     <= '0;
      answer_q    <= '0;
      miso_q      <= 1'b0;
      oe_n_q      <= 1'b1;
      wake_q      <= '0;
      busy_q      <= 1'b1;
      conv_q      <= '0;
      eoc_q       <= 1'b1;
      en_q        <= 1'b0;
      chan_q      <= 1'b0;
      result_q    <= '0;
    end else begin
      state_q     <= state_d;
      sclk_prev_q <= sclk_prev_d;
      instr_q     <= instr_d;
      count_q     <= count_d;
      answer_q    <= answer_d;
      miso_q      <= miso_d;
      oe_n_q      <= oe_n_d;
      wake_q      <= wake_d;
      busy_q      <= busy_d;
      conv_q      <= conv_d;
      eoc_q       <= eoc_d;
      en_q        <= en_d;
      chan_q      <= chan_d;
      result_q    <= result_d;
    end
  end

  assign miso_o       = miso_q;
  assign miso_oe_n_o  = oe_n_q;
  assign busy_o       = busy_q;
  assign adc_enable_o = en_q;
  assign adc_chan_o   = chan_q;
  assign conv_done_o  = eoc_q;
endmodule : spi_slave_command_port

// ===== rtl/spi_sync2.sv
module spi_sync2 (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  input  wire logic rst_val_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // both stages reset to zero; rst_val_i inverts the output so it reads rst_val_i during reset
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q ^ rst_val_i;
endmodule : spi_sync2

// ===== testbench/spi_master_model.sv
module spi_master_model (
  // link pins
  input  wire logic ref_clk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_n_i,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      ss_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wait_clk

  task automatic xfer(input logic [7:0] instr, input int nclk, output logic [15:0] ans);
    ans = 16'hxxxx;
    wait_clk(1);
    ss_n_o = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      mosi_o = (i < 8) ? instr[7-i] : 1'b0;
      wait_clk(4);
      sclk_o = 1'b1;
      if (i >= 8 && i < 24) begin
        ans[23-i] = miso_oe_n_i ? 1'bx : miso_i;
      end
      wait_clk(4);
      sclk_o = 1'b0;
    end
    wait_clk(4);
    ss_n_o = 1'b1;
    // released line has a pull-down
    mosi_o = 1'b0;
    wait_clk(8);
  endtask : xfer
endmodule : spi_master_model

// ===== testbench/spi_port_asserts.sv
module spi_port_asserts #(
  parameter int unsigned WAKE_CYCLES = 20,
  parameter int unsigned CONV_CYCLES = 10
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // link and status
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_n_o,
  input wire logic busy_o,
  input wire logic adc_enable_o,
  input wire logic adc_chan_o,
  input wire logic conv_done_o
);
  localparam int CMAX = CONV_CYCLES + 8;
  logic [31:0] wake_q;
  logic [31:0] wake_d;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // cycles spent busy since reset
  always_comb wake_d = busy_o ? wake_q + 32'h0000_0001 : wake_q;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) wake_q <= '0;
    else wake_q <= wake_d;
  end

  sequence s_desel; ss_n_i [*5]; endsequence
  sequence s_sel; !ss_n_i [*6]; endsequence
  property p_oe_off; s_desel |-> miso_oe_n_o; endproperty
  property p_oe_on; s_sel |-> !miso_oe_n_o; endproperty
  property p_miso_fall;
    !miso_oe_n_o && $past(!miso_oe_n_o) && $changed(miso_o) |-> !sclk_i && !$past(sclk_i, 3);
  endproperty
  property p_oe_rel; $rose(miso_oe_n_o) |-> $past(ss_n_i, 2); endproperty
  property p_busy_min; $fell(busy_o) |-> wake_q + 1 >= WAKE_CYCLES; endproperty
  property p_busy_max; busy_o |-> wake_q <= WAKE_CYCLES + 2; endproperty
  property p_busy_stay; !busy_o |=> !busy_o; endproperty
  property p_conv_len; $fell(conv_done_o) |-> ##[1:CMAX] conv_done_o; endproperty
  property p_conv_start; $fell(conv_done_o) |-> !ss_n_i ##[0:2] adc_enable_o; endproperty
  property p_cfg_sel; $changed(adc_enable_o) || $changed(adc_chan_o) |-> !$past(ss_n_i, 3); endproperty

  a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("miso not driven while selected");
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off falling clock");
  a_oe_rel: assert property (p_oe_rel) else $error("miso released without deselect");
  a_busy_min: assert property (p_busy_min) else $error("busy ended early");
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  a_busy_stay: assert property (p_busy_stay) else $error("busy came back");
  a_conv_len: assert property (p_conv_len) else $error("conversion too long");
  a_conv_start: assert property (p_conv_start) else $error("conversion without command");
  a_cfg_sel: assert property (p_cfg_sel) else $error("config changed while deselected");
endmodule : spi_port_asserts

// ===== testbench/tb_top.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end

module tb_top
  import spi_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WAKE = 300;
  localparam int unsigned CONV = 400;
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        sclk;
  logic        mosi;
  logic        ss_n;
  logic        miso;
  logic        miso_oe_n;
  adc_code_t   adc_sample = 11'h5A3;
  logic        busy;
  logic        adc_en;
  logic        adc_chan;
  logic        conv_done;
  logic [15:0] ans;
  int          errors  = 0;
  int          checked = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  spi_slave_command_port #(.WAKE_CYCLES(WAKE), .CONV_CYCLES(CONV)) i_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n),
    .miso_o(miso), .miso_oe_n_o(miso_oe_n), .adc_sample_i(adc_sample), .busy_o(busy),
    .adc_enable_o(adc_en), .adc_chan_o(adc_chan), .conv_done_o(conv_done));

  spi_master_model i_master (
    .ref_clk_i(ref_clk_i), .miso_i(miso), .miso_oe_n_i(miso_oe_n), .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n));

  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic t_busy;
    i_master.xfer(8'h88, 24, ans);
    `CHK(ans, 16'hA400)
    for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    `CHK(busy, 1'b0)
    $display("t_busy done");
  endtask : t_busy

  task automatic t_opc;
    i_master.xfer(8'hFF, 24, ans);
    `CHK(ans, 16'hE000)
    i_master.xfer(8'h00, 24, ans);
    `CHK(ans, 16'hE000)
    i_master.xfer(8'h88, 24, ans);
    `CHK(ans & 16'hA00C, 16'h2000)
    `CHK(miso_oe_n, 1'b1)
    $display("t_opc done");
  endtask : t_opc

  task automatic t_conv;
    i_master.xfer(8'h9C, 24, ans);
    `CHK(adc_en, 1'b1)
    `CHK(adc_chan, 1'b1)
    `CHK(conv_done, 1'b0)
    i_master.xfer(8'h9C, 24, ans);
    `CHK(ans, 16'h8000)
    for (int i = 0; i < 600 && conv_done !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    `CHK(conv_done, 1'b1)
    i_master.xfer(8'h80, 24, ans);
    `CHK(ans & 16'hAFFE, 16'h2B46)
    $display("t_conv done");
  endtask : t_conv

  task automatic t_trunc;
    i_master.xfer(8'h90, 7, ans);
    `CHK(adc_en, 1'b1)
    i_master.xfer(8'h88, 16, ans);
    `CHK(ans[15:8] & 8'hA0, 8'h20)
    `CHK(miso_oe_n, 1'b1)
    i_master.xfer(8'h88, 30, ans);
    `CHK(ans & 16'hA00C, 16'h200C)
    i_master.xfer(8'h90, 24, ans);
    `CHK(adc_en, 1'b0)
    i_master.xfer(8'h88, 24, ans);
    `CHK(ans & 16'h800C, 16'h0000)
    $display("t_trunc done");
  endtask : t_trunc

  initial begin
    #(20000 * 40);
    errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_busy();
    t_opc();
    t_conv();
    t_trunc();
    final_report();
  end
endmodule : tb_top

bind spi_slave_command_port spi_port_asserts #(.WAKE_CYCLES(WAKE_CYCLES), .CONV_CYCLES(CONV_CYCLES)) i_chk (
  .ref_clk_i, .reset_i, .sclk_i, .ss_n_i, .miso_o, .miso_oe_n_o, .busy_o, .adc_enable_o, .adc_chan_o, .conv_done_o);
